/* File: dv/tb_wdt_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb_wdt_top;
  logic       clk_sys     = 1'b0;
  logic       resetn      = 1'b0;
  logic       ce          = 1'b1;
  logic       pin_resetn  = 1'b1;
  logic       sub_clk_pin = 1'b0;
  logic       osc_tick    = 1'b0;
  logic [3:0] addr        = 4'h0;
  logic [7:0] wdata       = 8'h00;
  logic       wr_en       = 1'b0;
  logic       rd_en       = 1'b0;
  logic [7:0] rdata;
  logic       wdt_reset_out;
  logic [1:0] osc_div     = 2'h0;
  logic [7:0] v;
  logic [7:0] c1;
  bit         m_ck, m_key, m_run, m_flg;
  int         num_errors  = 0;
  int         checked     = 0;
  int         n_hold      = 0;
  int         n;

  // short counts keep the run small; expectations use the same figures
  wdt_top #(.DIV_SYS(16), .DIV_SUB(4), .HOLD_CYC(8)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .pin_resetn(pin_resetn), .sub_clk_pin(sub_clk_pin),
    .osc_tick(osc_tick), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .wdt_reset_out(wdt_reset_out));

  always #2.5 clk_sys = ~clk_sys;
  // subclock period unrelated to the system clock
  always #21 sub_clk_pin = ~sub_clk_pin;
  always @(posedge clk_sys) begin
    osc_div  <= osc_div + 2'h1;
    osc_tick <= (osc_div == 2'h3);
  end
  always @(negedge clk_sys) begin
    if (wdt_reset_out && osc_tick) n_hold++;
  end

  task end_sim;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // control write through the model; key is the value before the write
  task wc(input logic [7:0] d);
    bit k;
    k = m_key;
    wr(4'h0, d);
    if (!d[7]) m_ck = d[6];
    if (!d[5]) m_key = d[4];
    if (k && !d[3]) m_run = d[2];
    if (k && !d[1] && !d[0]) m_flg = 1'b0;
  endtask : wc

  task rc;
    rd(4'h0, v);
    `CHK(v, {1'b1, m_ck, 1'b1, m_key, 1'b1, m_run, 1'b1, m_flg})
  endtask : rc

  // count moves over a window exactly when the counter should run
  task span(input bit e);
    rd(4'h1, c1);
    repeat (200) @(posedge clk_sys);
    rd(4'h1, v);
    `CHK(v !== c1, e)
  endtask : span

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h4cd5b690));
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    rc();
    rd(4'h1, v);
    `CHK(v, 8'h00)
    rd(4'h2, v);
    `CHK(v, 8'hFF)
    rd(4'h3, v);
    `CHK(v, 8'h00)
    wr(4'hF, 8'hFF);
    rd(4'hF, v);
    `CHK(v, 8'h00)
    wc(8'h04);
    rc();
    wc(8'hBA);
    rc();
    wr(4'h1, 8'h55);
    rd(4'h1, v);
    `CHK(v, 8'h00)
    wc(8'h6A);
    wr(4'h1, 8'h55);
    rd(4'h1, v);
    `CHK(v, 8'h55)
    // a write while the clock enable is low must be lost
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(4'h1, 8'h33);
    ce <= 1'b1;
    rd(4'h1, v);
    `CHK(v, 8'h55)
    repeat (24) begin
      wc(8'($urandom));
      rc();
      if (!m_run && m_ck) begin
        // low half keeps the count clear of overflow in this loop
        c1 = {1'b0, 7'($urandom)};
        wr(4'h1, c1);
        rd(4'h1, v);
        `CHK(v, c1)
      end
    end
    wc(8'h9A);
    wc(8'h62);
    rc();
    wc(8'hA6);
    for (int s = 0; s < 2; s++) begin
      wr(4'h3, s ? 8'h20 : 8'h00);
      for (int m = 0; m < 6; m++) begin
        wr(4'h4, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h4, 8'(m));
        span(m < 2 || (m == 2 && s == 1));
        rc();
      end
    end
    wr(4'h4, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h2, 8'hFB);
    rd(4'h2, v);
    `CHK(v, 8'hFB)
    span(1'b1);
    wc(8'hA2);
    span(1'b0);
    wr(4'h2, 8'hFF);
    for (int t = 0; t < 2; t++) begin
      wr(4'h1, 8'hFE);
      wc(8'hA6);
      n_hold = 0;
      n = 0;
      while (!wdt_reset_out && n < 100) begin
        @(posedge clk_sys);
        #1 n++;
      end
      // two input ticks from FE, then the one-cycle reset delay
      `CHK(n >= 32 && n <= 34, 1'b1)
      `CHK(wdt_reset_out, 1'b1)
      m_flg = 1'b1;
      rd(4'h1, v);
      `CHK(v < 8'h02, 1'b1)
      rc();
      n = 0;
      while (wdt_reset_out && n < 200) begin
        @(posedge clk_sys);
        #1 n++;
      end
      `CHK(n_hold, 8)
      wc(8'hA2);
      wc(8'hA9);
      wc(8'hAA);
      rc();
      if (t == 0) begin
        @(posedge clk_sys);
        pin_resetn <= 1'b0;
        repeat (6) @(posedge clk_sys);
        pin_resetn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        m_flg = 1'b0;
      end else begin
        wc(8'hA8);
      end
      rc();
    end
    end_sim();
  end
endmodule : tb_wdt_top

/* File: hw/wdt_defs.svh */
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
// register offsets on the plain register port
`define WDT_OFS_CTRL     4'h0
`define WDT_OFS_COUNT    4'h1
`define WDT_OFS_CKSTOP   4'h2
`define WDT_OFS_PMODE    4'h3
`define WDT_OFS_MODE     4'h4
// control/status bit positions
`define WDT_B_CNT_INH    7
`define WDT_B_CNT_KEY    6
`define WDT_B_CTL_INH    5
`define WDT_B_CTL_KEY    4
`define WDT_B_ON_INH     3
`define WDT_B_RUN        2
`define WDT_B_FLG_INH    1
`define WDT_B_FLAG       0
// other bit positions
`define WDT_B_MOD_STOP   2
`define WDT_B_SRC_SEL    5
// reset values and the counter maximum
`define WDT_CKSTOP_RST   8'hFF
`define WDT_PMODE_RST    8'h00
`define WDT_COUNT_RST    8'h00
`define WDT_COUNT_MAX    8'hFF
// prescaler ratios and reset hold length
`define WDT_DIV_SYS      8192
`define WDT_DIV_SUB      32
`define WDT_HOLD_CYC     512
`endif

/* File: hw/wdt_pkg.sv */
package wdt_pkg;
  // power modes presented by the system controller
  typedef enum logic [2:0] {
    WDT_PM_ACTIVE    = 3'h0,
    WDT_PM_SLEEP     = 3'h1,
    WDT_PM_SUBACTIVE = 3'h2,
    WDT_PM_WATCH     = 3'h3,
    WDT_PM_SUBSLEEP  = 3'h4,
    WDT_PM_STANDBY   = 3'h5
  } wdt_pmode_t;
  typedef enum logic [1:0] {
    WDT_ST_IDLE  = 2'b00,
    WDT_ST_DELAY = 2'b01,
    WDT_ST_HOLD  = 2'b11
  } wdt_state_t;
endpackage : wdt_pkg

/* File: hw/wdt_prescaler.sv */
`timescale 1ns/1ps
`include "wdt_defs.svh"
// divider, cleared while run is low, giving one-cycle ticks of the chosen source
module wdt_prescaler #(
  parameter int DIV_SYS = `WDT_DIV_SYS,
  parameter int DIV_SUB = `WDT_DIV_SUB
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic run,
  input  wire logic sub_tick,
  input  wire logic src_sub,
  output logic      tick
);
  localparam int W = $clog2(DIV_SYS);
  logic [W-1:0] cnt_reg, cnt_next;
  logic [W-1:0] lim;

  always_comb begin
    lim = src_sub ? W'(DIV_SUB - 1) : W'(DIV_SYS - 1);
    cnt_next = cnt_reg;
    tick = 1'b0;
    if (!run) begin
      cnt_next = '0;
    end else if (!src_sub || sub_tick) begin
      if (cnt_reg >= lim) begin
        cnt_next = '0;
        tick = 1'b1;
      end else begin
        cnt_next = cnt_reg + W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : wdt_prescaler

/* File: hw/wdt_top.sv */
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_top #(
  parameter int DIV_SYS  = `WDT_DIV_SYS,
  parameter int DIV_SUB  = `WDT_DIV_SUB,
  parameter int HOLD_CYC = `WDT_HOLD_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       pin_resetn,
  input  wire logic       sub_clk_pin,
  input  wire logic       osc_tick,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  output logic            wdt_reset_out
);
  // sync chains for the subclock pin and the reset pin
  logic [2:0] sub_sync_reg;
  logic [2:0] pin_sync_reg;
  logic       sub_lvl_reg;
  logic       pin_lvl_reg;
  logic       sub_lvl_next;
  logic       pin_lvl_next;
  logic       sub_tick;

  always_comb begin
    sub_lvl_next = sub_lvl_reg;
    pin_lvl_next = pin_lvl_reg;
    if (sub_sync_reg[1] == sub_sync_reg[2]) begin
      sub_lvl_next = sub_sync_reg[2];
    end
    if (pin_sync_reg[1] == pin_sync_reg[2]) begin
      pin_lvl_next = pin_sync_reg[2];
    end
  end
  assign sub_tick = sub_lvl_next & ~sub_lvl_reg;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sub_sync_reg <= 3'h0;
      pin_sync_reg <= 3'h7;
      sub_lvl_reg  <= 1'b0;
      pin_lvl_reg  <= 1'b1;
    end else if (ce) begin
      sub_sync_reg <= {sub_sync_reg[1:0], sub_clk_pin};
      pin_sync_reg <= {pin_sync_reg[1:0], pin_resetn};
      sub_lvl_reg  <= sub_lvl_next;
      pin_lvl_reg  <= pin_lvl_next;
    end
  end

  // register state
  localparam int HOLD_W = $clog2(HOLD_CYC + 1);
  logic             cnt_key_reg, cnt_key_next;
  logic             ctl_key_reg, ctl_key_next;
  logic             run_reg,     run_next;
  logic             flag_reg,    flag_next;
  logic       [7:0] count_reg,   count_next;
  logic       [7:0] ckstop_reg,  ckstop_next;
  logic       [7:0] pmode_reg,   pmode_next;
  wdt_pkg::wdt_pmode_t pm_reg,   pm_next;
  logic       [7:0] rdata_next;
  wdt_pkg::wdt_state_t st_reg,   st_next;
  logic [HOLD_W-1:0] hold_reg,   hold_next;
  logic             ovf;
  logic             tick;
  logic             src_sub;
  logic             mod_stop;
  logic             halted;
  logic             active;
  logic             pin_fall;

  assign src_sub  = pmode_reg[`WDT_B_SRC_SEL];
  // standby bit only bites once the watchdog is off
  assign mod_stop = ~ckstop_reg[`WDT_B_MOD_STOP] & ~run_reg;
  always_comb begin
    unique case (pm_reg)
      wdt_pkg::WDT_PM_ACTIVE,
      wdt_pkg::WDT_PM_SLEEP:     halted = 1'b0;
      wdt_pkg::WDT_PM_SUBACTIVE: halted = ~src_sub;
      default:                   halted = 1'b1;
    endcase
  end
  assign active   = run_reg & ~mod_stop & ~halted;
  assign pin_fall = pin_lvl_reg & ~pin_lvl_next;

  wdt_prescaler #(
    .DIV_SYS (DIV_SYS),
    .DIV_SUB (DIV_SUB)
  ) u_pre (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .ce       (ce),
    .run      (active),
    .sub_tick (sub_tick),
    .src_sub  (src_sub),
    .tick     (tick)
  );

  logic wr_ctl, wr_cnt;
  assign wr_ctl = wr_en & (addr == `WDT_OFS_CTRL);
  assign wr_cnt = wr_en & (addr == `WDT_OFS_COUNT);
  assign ovf = tick & (count_reg == `WDT_COUNT_MAX);

  always_comb begin
    cnt_key_next = cnt_key_reg;
    ctl_key_next = ctl_key_reg;
    run_next     = run_reg;
    flag_next    = flag_reg;
    count_next   = count_reg;
    ckstop_next  = ckstop_reg;
    pmode_next   = pmode_reg;
    pm_next      = pm_reg;
    // halted modes freeze the count; only the bus and the reset pin still reach these registers
    if (tick) begin
      count_next = count_reg + 8'h01;
    end
    if (wr_ctl) begin
      if (!wdata[`WDT_B_CNT_INH]) begin
        cnt_key_next = wdata[`WDT_B_CNT_KEY];
      end
      if (!wdata[`WDT_B_CTL_INH]) begin
        ctl_key_next = wdata[`WDT_B_CTL_KEY];
      end
      if (ctl_key_reg && !wdata[`WDT_B_ON_INH]) begin
        run_next = wdata[`WDT_B_RUN];
      end
      if (ctl_key_reg && !wdata[`WDT_B_FLG_INH] && !wdata[`WDT_B_FLAG]) begin
        flag_next = 1'b0;
      end
    end
    if (wr_cnt && cnt_key_reg) begin
      count_next = wdata;
    end
    if (wr_en && addr == `WDT_OFS_CKSTOP) begin
      ckstop_next = wdata;
    end
    if (wr_en && addr == `WDT_OFS_PMODE) begin
      pmode_next = wdata;
    end
    if (wr_en && addr == `WDT_OFS_MODE) begin
      pm_next = wdt_pkg::wdt_pmode_t'(wdata[2:0]);
    end
    // set wins over a same-cycle software clear; a pin clear wins over both
    if (ovf) begin
      flag_next = 1'b1;
    end
    if (pin_fall) begin
      flag_next = 1'b0;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (rd_en) begin
      unique case (addr)
        `WDT_OFS_CTRL:   rdata_next = {1'b1, cnt_key_reg, 1'b1, ctl_key_reg,
                                       1'b1, run_reg, 1'b1, flag_reg};
        `WDT_OFS_COUNT:  rdata_next = count_reg;
        `WDT_OFS_CKSTOP: rdata_next = ckstop_reg;
        `WDT_OFS_PMODE:  rdata_next = pmode_reg;
        `WDT_OFS_MODE:   rdata_next = {5'h00, pm_reg};
        default:         rdata_next = 8'h00;
      endcase
    end
  end

  // internal reset sequencer: one base cycle delay, then 512 osc cycles
  always_comb begin
    st_next   = st_reg;
    hold_next = hold_reg;
    unique case (st_reg)
      wdt_pkg::WDT_ST_IDLE: begin
        if (ovf) begin
          st_next = wdt_pkg::WDT_ST_DELAY;
        end
      end
      wdt_pkg::WDT_ST_DELAY: begin
        st_next   = wdt_pkg::WDT_ST_HOLD;
        hold_next = HOLD_W'(HOLD_CYC - 1);
      end
      wdt_pkg::WDT_ST_HOLD: begin
        if (osc_tick) begin
          if (hold_reg == '0) begin
            st_next = wdt_pkg::WDT_ST_IDLE;
          end else begin
            hold_next = hold_reg - HOLD_W'(1);
          end
        end
      end
      default: st_next = wdt_pkg::WDT_ST_IDLE;
    endcase
  end
  assign wdt_reset_out = (st_reg == wdt_pkg::WDT_ST_HOLD);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_key_reg <= 1'b0;
      ctl_key_reg <= 1'b0;
      run_reg     <= 1'b0;
      flag_reg    <= 1'b0;
      count_reg   <= `WDT_COUNT_RST;
      ckstop_reg  <= `WDT_CKSTOP_RST;
      pmode_reg   <= `WDT_PMODE_RST;
      pm_reg      <= wdt_pkg::WDT_PM_ACTIVE;
      rdata       <= 8'h00;
      st_reg      <= wdt_pkg::WDT_ST_IDLE;
      hold_reg    <= '0;
    end else if (ce) begin
      cnt_key_reg <= cnt_key_next;
      ctl_key_reg <= ctl_key_next;
      run_reg     <= run_next;
      flag_reg    <= flag_next;
      count_reg   <= count_next;
      ckstop_reg  <= ckstop_next;
      pmode_reg   <= pmode_next;
      pm_reg      <= pm_next;
      rdata       <= rdata_next;
      st_reg      <= st_next;
      hold_reg    <= hold_next;
    end
  end

  // every check below runs on the one clock and sleeps through reset
  default clocking ast_cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // flag survives the internal reset: it is cleared only by resetn, the reset pin or software
  AST_OVF_FLAG: assert property (
    ce && ovf && !pin_fall |=> flag_reg)
    else $error("flag not set on overflow");

  AST_RST_DELAY: assert property (
    ce && ovf && st_reg == wdt_pkg::WDT_ST_IDLE ##1 ce |=> wdt_reset_out)
    else $error("internal reset not raised after overflow");

  AST_NO_COUNT_OFF: assert property (
    ce && !run_reg && !wr_cnt |=> count_reg == $past(count_reg))
    else $error("counter moved while off");

  AST_TICK_RUN: assert property (
    tick |-> run_reg && !halted)
    else $error("count tick while stopped");

  AST_CNT_INC: assert property (
    ce && tick && !wr_cnt |=> count_reg == $past(count_reg) + 8'h01)
    else $error("counter did not advance on tick");

  AST_HALT_FREEZE: assert property (
    ce && halted && !wr_cnt |=> count_reg == $past(count_reg))
    else $error("counter moved while halted");

  AST_RUN_LOCK: assert property (
    ce && !ctl_key_reg |=> run_reg == $past(run_reg))
    else $error("run bit changed without key");

  AST_RUN_INH: assert property (
    ce && wr_ctl && wdata[`WDT_B_ON_INH] |=> run_reg == $past(run_reg))
    else $error("run bit changed with inhibit");

  AST_RUN_SET: assert property (
    ce && wr_ctl && ctl_key_reg && !wdata[`WDT_B_ON_INH] |=>
      run_reg == $past(wdata[`WDT_B_RUN]))
    else $error("run bit not written with key");

  AST_KEY_INH: assert property (
    ce && wr_ctl && !wdata[`WDT_B_CTL_INH] |=>
      ctl_key_reg == $past(wdata[`WDT_B_CTL_KEY]))
    else $error("key bit not written");

  AST_KEY_HOLD: assert property (
    ce && !(wr_ctl && !wdata[`WDT_B_CTL_INH]) |=>
      ctl_key_reg == $past(ctl_key_reg))
    else $error("key bit moved with inhibit set");

  AST_CKEY_WR: assert property (
    ce && wr_ctl && !wdata[`WDT_B_CNT_INH] |=>
      cnt_key_reg == $past(wdata[`WDT_B_CNT_KEY]))
    else $error("counter key not written");

  AST_CNT_LOCK: assert property (
    ce && wr_cnt && cnt_key_reg && !tick |=> count_reg == $past(wdata))
    else $error("counter write lost");

  AST_CNT_KEY: assert property (
    ce && wr_cnt && !cnt_key_reg && !tick |=> count_reg == $past(count_reg))
    else $error("counter written without key");

  AST_FLAG_CLR: assert property (
    ce && wr_ctl && ctl_key_reg && !wdata[`WDT_B_FLG_INH] &&
      !wdata[`WDT_B_FLAG] && !ovf |=> !flag_reg)
    else $error("flag not cleared by software");

  AST_FLAG_INH: assert property (
    ce && wr_ctl && wdata[`WDT_B_FLG_INH] && !ovf && !pin_fall |=>
      flag_reg == $past(flag_reg))
    else $error("flag changed with inhibit set");

  AST_PIN_CLR: assert property (
    ce && pin_fall |=> !flag_reg)
    else $error("pin reset left the flag set");

  AST_HOLD_STAY: assert property (
    ce && wdt_reset_out && !(osc_tick && hold_reg == '0) |=> wdt_reset_out)
    else $error("internal reset dropped early");

  AST_HOLD_END: assert property (
    ce && wdt_reset_out && osc_tick && hold_reg == '0 |=> !wdt_reset_out)
    else $error("internal reset held too long");

  AST_READ_CTL: assert property (
    ce && rd_en && addr == `WDT_OFS_CTRL |=> rdata[7] && rdata[5] &&
      rdata[3] && rdata[1])
    else $error("inhibit bits not read as one");

  COV_OVF: cover property (@(posedge clk_sys) ovf);
  COV_HOLD_END: cover property (@(posedge clk_sys)
    wdt_reset_out ##1 !wdt_reset_out);
  COV_DEFER: cover property (@(posedge clk_sys)
    run_reg && !ckstop_reg[`WDT_B_MOD_STOP]);
  COV_SUB_SRC: cover property (@(posedge clk_sys) tick && src_sub);
  COV_PIN_CLR: cover property (@(posedge clk_sys) pin_fall && flag_reg);
endmodule : wdt_top
